// [common/hup_pkg.sv]
package hup_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int FIFO_DEPTH = 8;
    // Host register map, byte wide, address on the select lines
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_IRQ_EN = 3'h1;
    localparam logic [2:0] REG_STATUS = 3'h5;
    localparam logic [2:0] REG_SCRATCH = 3'h7;
    localparam int STAT_RX_BIT = 0;
    localparam int STAT_TX_BIT = 5;
    localparam int IEN_RX_BIT = 0;
    localparam int IEN_TX_BIT = 1;
    localparam int IEN_DMA_BIT = 3;
    localparam logic [7:0] IEN_RESET = 8'h00;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    // Host access phase lengths in clocks
    localparam int STROBE_CYCLES = 4;
    localparam int SETUP_CYCLES = 1;
    typedef enum logic [1:0] {
        HUP_IDLE = 2'b00,
        HUP_SETUP = 2'b01,
        HUP_STROBE = 2'b11,
        HUP_HOLD = 2'b10
    } hup_host_state_t;
endpackage

// [common/hup_if.sv]
`timescale 1ns/10ps
interface hup_if;
    logic mode_i;
    logic [7:0] data_dev_o;
    logic data_dev_oe;
    logic [7:0] data_host_o;
    logic data_host_oe;
    logic [2:0] reg_sel;
    logic select_n;
    logic write_n;
    logic read_n;
    logic buffer_off_n;
    logic irq;
    logic tx_slot_free_n;
    logic rx_byte_ready_n;
    wire [7:0] host_data_bus = data_dev_oe ? data_dev_o : data_host_oe ? data_host_o : 8'h00;
    modport device (input mode_i, input host_data_bus, output data_dev_o, output data_dev_oe,
        input reg_sel, input select_n, input write_n, input read_n, output buffer_off_n,
        output irq, output tx_slot_free_n, output rx_byte_ready_n);
    modport host (input host_data_bus, output data_host_o, output data_host_oe,
        output reg_sel, output select_n, output write_n, output read_n, input buffer_off_n,
        input irq, input tx_slot_free_n, input rx_byte_ready_n);
endinterface

// [rtl/hup_fifo.sv]
`timescale 1ns/10ps
module hup_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_ff != '0;
    assign out_data_o = mem_ff[rd_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // hup_fifo

// [rtl/hup_device_end.sv]
`timescale 1ns/10ps
// Functional notes
// - Mode 1 data bus, mode 0 port A
// - Buffer off low during host read
// - Register select chooses addressed register
// - Strobes ignored unless host selected
// - Write strobe captures data into register
// - Read strobe drives addressed register out
// - Irq high while interrupt pending
// - DMA tx-free low when holding empty
// - DMA rx-ready low when byte waiting
// - Mode 0 select/write/read go serial B
// - Unselected port: address pins serve serial B
// - Unselected port: buffer off pin is TxD
// - Mode 0 irq pin shares serial functions
// - Mode 0 ready pins share serial functions
module hup_device_end #(
    parameter int DEPTH = hup_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic reset_i,
    hup_if.device host,
    // Local side: bytes the host wrote
    output logic [7:0] rx_from_host_data_o,
    output logic rx_from_host_valid_o,
    input wire logic rx_from_host_ready_i,
    // Local side: bytes for the host to read
    input wire logic [7:0] tx_to_host_data_i,
    input wire logic tx_to_host_valid_i,
    // Mode 0 alternate functions, then tx_to_host_ready_o for the local side
    input wire logic [7:0] general_port_a_out_i,
    input wire logic [7:0] general_port_a_oe_i,
    output logic [7:0] general_port_a_in_o,
    output logic serial_b_sync_o,
    output logic serial_b_clear_to_send_o,
    output logic serial_b_carrier_detect_o,
    output logic serial_b_trx_clock_o,
    output logic serial_b_receive_data_o,
    output logic serial_b_rtx_clock_o,
    input wire logic serial_b_transmit_data_i,
    input wire logic serial_b_terminal_ready_request_i,
    input wire logic clocked_serial_transmit_i,
    input wire logic csio_transmit_select_i,
    input wire logic serial_b_wait_request_i,
    input wire logic clocked_serial_clock_i,
    input wire logic csio_clock_select_i,
    input wire logic serial_b_request_to_send_i,
    input wire logic dma1_transfer_end_n_i,
    input wire logic dma1_end_select_i,
    output logic tx_to_host_ready_o
);
    logic [1:0] sel_sync_ff, wr_sync_ff, rd_sync_ff;
    logic [2:0] addr_s1_ff, addr_s2_ff;
    logic [7:0] data_s1_ff, data_s2_ff;
    logic wr_prev_ff;
    logic rd_prev_ff;
    logic [7:0] ien_ff;
    logic [7:0] scratch_ff;
    logic [7:0] rd_data_ff;
    logic mode1;
    logic sel_act, wr_act, rd_act, wr_rise, rd_rise;
    logic [7:0] rx_q_data;
    logic rx_q_valid, rx_q_ready;
    logic wr_push;
    logic rx_in_ready;
    logic [7:0] read_value;

    assign mode1 = host.mode_i;

    // Strobe pins are asynchronous to clk_i
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sel_sync_ff <= 2'h3;
            wr_sync_ff <= 2'h3;
            rd_sync_ff <= 2'h3;
            addr_s1_ff <= 3'h0;
            addr_s2_ff <= 3'h0;
            data_s1_ff <= 8'h00;
            data_s2_ff <= 8'h00;
        end else begin
            sel_sync_ff <= {sel_sync_ff[0], host.select_n};
            wr_sync_ff <= {wr_sync_ff[0], host.write_n};
            rd_sync_ff <= {rd_sync_ff[0], host.read_n};
            addr_s1_ff <= host.reg_sel;
            addr_s2_ff <= addr_s1_ff;
            data_s1_ff <= host.host_data_bus;
            data_s2_ff <= data_s1_ff;
        end
    end

    assign sel_act = mode1 && !sel_sync_ff[1];
    assign wr_act = sel_act && !wr_sync_ff[1];
    assign rd_act = sel_act && !rd_sync_ff[1];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_prev_ff <= 1'b0;
            rd_prev_ff <= 1'b0;
        end else begin
            wr_prev_ff <= wr_act;
            rd_prev_ff <= rd_act;
        end
    end

    // Commit on strobe release so data and address have settled
    assign wr_rise = wr_prev_ff && !wr_act;
    assign rd_rise = rd_prev_ff && !rd_act;
    assign wr_push = wr_rise && addr_s2_ff == hup_pkg::REG_DATA;

    hup_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_data_i(data_s2_ff),
        .in_valid_i(wr_push),
        .in_ready_o(rx_in_ready),
        .out_data_o(rx_from_host_data_o),
        .out_valid_o(rx_from_host_valid_o),
        .out_ready_i(rx_from_host_ready_i)
    );

    // Local bytes toward the host; read of data register pops one
    hup_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_data_i(tx_to_host_data_i),
        .in_valid_i(tx_to_host_valid_i),
        .in_ready_o(tx_to_host_ready_o),
        .out_data_o(rx_q_data),
        .out_valid_o(rx_q_valid),
        .out_ready_i(rx_q_ready)
    );
    assign rx_q_ready = rd_rise && addr_s2_ff == hup_pkg::REG_DATA;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ien_ff <= hup_pkg::IEN_RESET;
            scratch_ff <= hup_pkg::SCRATCH_RESET;
        end else if (wr_rise) begin
            unique case (addr_s2_ff)
                hup_pkg::REG_IRQ_EN: ien_ff <= data_s2_ff;
                hup_pkg::REG_SCRATCH: scratch_ff <= data_s2_ff;
                default: ;
            endcase
        end
    end

    always_comb begin
        read_value = 8'h00;
        unique case (addr_s2_ff)
            hup_pkg::REG_DATA: read_value = rx_q_data;
            hup_pkg::REG_IRQ_EN: read_value = ien_ff;
            hup_pkg::REG_STATUS: begin
                read_value[hup_pkg::STAT_RX_BIT] = rx_q_valid;
                read_value[hup_pkg::STAT_TX_BIT] = rx_in_ready && !rx_from_host_valid_o;
            end
            hup_pkg::REG_SCRATCH: read_value = scratch_ff;
            default: read_value = 8'h00;
        endcase
    end

    // Hold value steady while rd_prev_ff is high, from late in the read strobe until three clocks after it ends
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_data_ff <= 8'h00;
        end else if (!rd_prev_ff) begin
            rd_data_ff <= read_value;
        end
    end

    logic sel_pin_rd, dma_on, irq_pend, tx_empty;
    // Raw pins so the bus turns on as soon as the host asks
    assign sel_pin_rd = mode1 && !host.select_n && !host.read_n;
    assign dma_on = ien_ff[hup_pkg::IEN_DMA_BIT];
    assign tx_empty = !rx_from_host_valid_o;
    assign irq_pend = (ien_ff[hup_pkg::IEN_RX_BIT] && rx_q_valid)
        || (ien_ff[hup_pkg::IEN_TX_BIT] && tx_empty);

    always_comb begin
        if (mode1) begin
            host.data_dev_o = sel_pin_rd ? rd_data_ff : 8'h00;
            host.data_dev_oe = sel_pin_rd;
            host.buffer_off_n = !sel_pin_rd;
            host.irq = irq_pend;
            host.tx_slot_free_n = !(dma_on && tx_empty);
            host.rx_byte_ready_n = !(dma_on && rx_q_valid);
        end else begin
            host.data_dev_o = general_port_a_out_i;
            host.data_dev_oe = |general_port_a_oe_i;
            host.buffer_off_n = serial_b_transmit_data_i;
            host.irq = csio_transmit_select_i ? clocked_serial_transmit_i
                : serial_b_terminal_ready_request_i;
            host.tx_slot_free_n = csio_clock_select_i ? clocked_serial_clock_i
                : serial_b_wait_request_i;
            host.rx_byte_ready_n = dma1_end_select_i ? dma1_transfer_end_n_i
                : serial_b_request_to_send_i;
        end
    end

    // Mode 0 inputs taken from the shared pins
    assign general_port_a_in_o = mode1 ? 8'h00 : data_s2_ff;
    assign serial_b_sync_o = mode1 ? 1'b1 : sel_sync_ff[1];
    assign serial_b_clear_to_send_o = mode1 ? 1'b1 : wr_sync_ff[1];
    assign serial_b_carrier_detect_o = mode1 ? 1'b1 : rd_sync_ff[1];
    assign serial_b_trx_clock_o = mode1 ? 1'b1 : addr_s2_ff[0];
    assign serial_b_receive_data_o = mode1 ? 1'b1 : addr_s2_ff[1];
    assign serial_b_rtx_clock_o = mode1 ? 1'b1 : addr_s2_ff[2];
endmodule // hup_device_end

// [rtl/hup_host_end.sv]
`timescale 1ns/10ps
module hup_host_end (
    input wire logic clk_i,
    input wire logic reset_i,
    hup_if.host dev,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [2:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    output logic req_ready_o,
    output logic [7:0] rsp_rdata_o,
    output logic rsp_valid_o,
    output logic irq_o,
    output logic tx_slot_free_o,
    output logic rx_byte_ready_o
);
    hup_pkg::hup_host_state_t state_ff;
    logic [2:0] cnt_ff;
    logic write_ff;
    logic [2:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] rdata_ff;
    logic rsp_ff;
    logic [1:0] irq_s_ff, txr_s_ff, rxr_s_ff;
    logic [7:0] bus_s1_ff, bus_s2_ff;

    assign req_ready_o = state_ff == hup_pkg::HUP_IDLE;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= hup_pkg::HUP_IDLE;
            cnt_ff <= 3'h0;
            write_ff <= 1'b0;
            addr_ff <= 3'h0;
            wdata_ff <= 8'h00;
        end else begin
            unique case (state_ff)
                hup_pkg::HUP_IDLE: if (req_valid_i) begin
                    write_ff <= req_write_i;
                    addr_ff <= req_addr_i;
                    wdata_ff <= req_wdata_i;
                    cnt_ff <= 3'(hup_pkg::SETUP_CYCLES);
                    state_ff <= hup_pkg::HUP_SETUP;
                end
                hup_pkg::HUP_SETUP: begin
                    cnt_ff <= 3'(hup_pkg::STROBE_CYCLES);
                    state_ff <= hup_pkg::HUP_STROBE;
                end
                hup_pkg::HUP_STROBE: if (cnt_ff == 3'h1) begin
                    state_ff <= hup_pkg::HUP_HOLD;
                end else begin
                    cnt_ff <= cnt_ff - 3'h1;
                end
                hup_pkg::HUP_HOLD: state_ff <= hup_pkg::HUP_IDLE;
            endcase
        end
    end

    logic active, strobe;
    assign active = state_ff != hup_pkg::HUP_IDLE;
    assign strobe = state_ff == hup_pkg::HUP_STROBE;
    assign dev.select_n = !active;
    assign dev.reg_sel = addr_ff;
    assign dev.write_n = !(strobe && write_ff);
    assign dev.read_n = !(strobe && !write_ff);
    assign dev.data_host_oe = active && write_ff;
    assign dev.data_host_o = wdata_ff;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bus_s1_ff <= 8'h00;
            bus_s2_ff <= 8'h00;
            irq_s_ff <= 2'h0;
            txr_s_ff <= 2'h3;
            rxr_s_ff <= 2'h3;
        end else begin
            bus_s1_ff <= dev.host_data_bus;
            bus_s2_ff <= bus_s1_ff;
            irq_s_ff <= {irq_s_ff[0], dev.irq};
            txr_s_ff <= {txr_s_ff[0], dev.tx_slot_free_n};
            rxr_s_ff <= {rxr_s_ff[0], dev.rx_byte_ready_n};
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= 8'h00;
            rsp_ff <= 1'b0;
        end else begin
            rsp_ff <= state_ff == hup_pkg::HUP_HOLD && !write_ff;
            if (state_ff == hup_pkg::HUP_HOLD && !write_ff) begin
                rdata_ff <= bus_s2_ff;
            end
        end
    end
    assign rsp_rdata_o = rdata_ff;
    assign rsp_valid_o = rsp_ff;
    assign irq_o = irq_s_ff[1];
    assign tx_slot_free_o = !txr_s_ff[1];
    assign rx_byte_ready_o = !rxr_s_ff[1];
endmodule // hup_host_end

// [verification/hup_props.sv]
`timescale 1ns/10ps
module hup_props (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic mode_i,
    input wire logic [7:0] data_dev_o,
    input wire logic data_dev_oe,
    input wire logic [7:0] host_data_bus,
    input wire logic [2:0] reg_sel,
    input wire logic select_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic buffer_off_n
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_strobe_low;
        (!read_n || !write_n) [*4];
    endsequence
    sequence s_release;
        !select_n ##1 select_n;
    endsequence

    a_strobe_len: assert property (
        ($fell(read_n) || $fell(write_n)) |-> s_strobe_low ##1 (read_n && write_n))
        else $error("strobe length wrong");
    a_hold_release: assert property (
        ($rose(read_n) || $rose(write_n)) |-> s_release)
        else $error("select not released after hold");
    a_setup_first: assert property (
        $fell(select_n) |-> (read_n && write_n) ##1 (!read_n || !write_n))
        else $error("setup phase wrong");
    a_strobe_selected: assert property (
        (!read_n || !write_n) |-> !select_n)
        else $error("strobe without select");
    a_one_strobe: assert property (!(!read_n && !write_n))
        else $error("read and write together");
    a_addr_stable: assert property (
        (!select_n && !$past(select_n)) |-> $stable(reg_sel))
        else $error("address moved in access");
    a_drive_read_only: assert property (
        (mode_i && data_dev_oe) |-> (!select_n && !read_n))
        else $error("device drives outside read");
    a_buffer_off_read: assert property (
        (mode_i && !select_n && !read_n) |-> !buffer_off_n)
        else $error("buffer off high during read");
    a_bus_value: assert property (
        data_dev_oe |-> host_data_bus == data_dev_o)
        else $error("bus not showing device data");
    c_read: cover property (!read_n && data_dev_oe);
endmodule // hup_props

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    logic clk_i, reset_i, req_valid_i, req_write_i, rx_from_host_ready_i, tx_to_host_valid_i;
    logic [2:0] req_addr_i;
    logic [7:0] req_wdata_i, tx_to_host_data_i, general_port_a_out_i, general_port_a_oe_i, q;
    logic serial_b_transmit_data_i, serial_b_terminal_ready_request_i, clocked_serial_transmit_i;
    logic csio_transmit_select_i, serial_b_wait_request_i, clocked_serial_clock_i;
    logic csio_clock_select_i, serial_b_request_to_send_i, dma1_transfer_end_n_i, dma1_end_select_i;
    logic req_ready_o, rsp_valid_o, irq_o, tx_slot_free_o, rx_byte_ready_o, tx_to_host_ready_o;
    logic [7:0] rsp_rdata_o, rx_from_host_data_o, general_port_a_in_o;
    logic rx_from_host_valid_o, serial_b_sync_o, serial_b_clear_to_send_o;
    logic serial_b_carrier_detect_o, serial_b_trx_clock_o, serial_b_receive_data_o;
    logic serial_b_rtx_clock_o;
    int bad_count, total_checks, n;
    typedef struct {logic wr; logic [2:0] a; logic [7:0] d; logic [7:0] e;} hup_row_t;
    hup_row_t rows[7];

    hup_if hup_if_inst();
    hup_device_end #(.DEPTH(8)) hup_device_end_inst (.clk_i(clk_i), .reset_i(reset_i),
        .host(hup_if_inst), .rx_from_host_data_o(rx_from_host_data_o),
        .rx_from_host_valid_o(rx_from_host_valid_o), .rx_from_host_ready_i(rx_from_host_ready_i),
        .tx_to_host_data_i(tx_to_host_data_i), .tx_to_host_valid_i(tx_to_host_valid_i),
        .general_port_a_out_i(general_port_a_out_i), .general_port_a_oe_i(general_port_a_oe_i),
        .general_port_a_in_o(general_port_a_in_o), .serial_b_sync_o(serial_b_sync_o),
        .serial_b_clear_to_send_o(serial_b_clear_to_send_o),
        .serial_b_carrier_detect_o(serial_b_carrier_detect_o),
        .serial_b_trx_clock_o(serial_b_trx_clock_o),
        .serial_b_receive_data_o(serial_b_receive_data_o),
        .serial_b_rtx_clock_o(serial_b_rtx_clock_o),
        .serial_b_transmit_data_i(serial_b_transmit_data_i),
        .serial_b_terminal_ready_request_i(serial_b_terminal_ready_request_i),
        .clocked_serial_transmit_i(clocked_serial_transmit_i),
        .csio_transmit_select_i(csio_transmit_select_i),
        .serial_b_wait_request_i(serial_b_wait_request_i),
        .clocked_serial_clock_i(clocked_serial_clock_i),
        .csio_clock_select_i(csio_clock_select_i),
        .serial_b_request_to_send_i(serial_b_request_to_send_i),
        .dma1_transfer_end_n_i(dma1_transfer_end_n_i), .dma1_end_select_i(dma1_end_select_i),
        .tx_to_host_ready_o(tx_to_host_ready_o));
    hup_host_end hup_host_end_inst (.clk_i(clk_i), .reset_i(reset_i), .dev(hup_if_inst),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_rdata_o(rsp_rdata_o),
        .rsp_valid_o(rsp_valid_o), .irq_o(irq_o), .tx_slot_free_o(tx_slot_free_o),
        .rx_byte_ready_o(rx_byte_ready_o));
    hup_props hup_props_inst (.clk_i(clk_i), .reset_i(reset_i), .mode_i(hup_if_inst.mode_i),
        .data_dev_o(hup_if_inst.data_dev_o), .data_dev_oe(hup_if_inst.data_dev_oe),
        .host_data_bus(hup_if_inst.host_data_bus), .reg_sel(hup_if_inst.reg_sel),
        .select_n(hup_if_inst.select_n), .write_n(hup_if_inst.write_n),
        .read_n(hup_if_inst.read_n), .buffer_off_n(hup_if_inst.buffer_off_n));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Entered and left at a falling edge; valid held one cycle only
    task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
        n = 0;
        while (req_ready_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        n = 0;
        if (!wr) begin
            while (rsp_valid_o !== 1'b1 && n < 40) begin
                @(negedge clk_i);
                n++;
            end
            q = rsp_rdata_o;
            chk1(rsp_valid_o, 1'b1);
        end
    endtask
    task automatic wait_n(input int c);
        repeat (c) @(negedge clk_i);
    endtask

    initial begin
        #50000;
        bad_count++;
        summarize();
    end

    initial begin
        {req_valid_i, req_write_i, req_addr_i, req_wdata_i, tx_to_host_valid_i} = '0;
        {tx_to_host_data_i, general_port_a_out_i, general_port_a_oe_i} = '0;
        {serial_b_transmit_data_i, serial_b_terminal_ready_request_i} = '0;
        {clocked_serial_transmit_i, csio_transmit_select_i, serial_b_wait_request_i} = '0;
        {clocked_serial_clock_i, csio_clock_select_i, serial_b_request_to_send_i} = '0;
        {dma1_transfer_end_n_i, dma1_end_select_i} = 2'b10;
        rx_from_host_ready_i = 1'b0;
        hup_if_inst.mode_i = 1'b1;
        reset_i = 1'b1;
        rows = '{'{0, hup_pkg::REG_IRQ_EN, 8'h00, hup_pkg::IEN_RESET},
            '{0, hup_pkg::REG_SCRATCH, 8'h00, hup_pkg::SCRATCH_RESET},
            '{1, hup_pkg::REG_SCRATCH, 8'ha5, 8'h00},
            '{0, hup_pkg::REG_SCRATCH, 8'h00, 8'ha5},
            '{0, 3'h2, 8'h00, 8'h00},
            '{0, 3'h6, 8'h00, 8'h00},
            '{0, hup_pkg::REG_STATUS, 8'h00, 8'h20}};
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        chk1(hup_if_inst.irq, 1'b0);
        foreach (rows[i]) begin
            xfer(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk8(q, rows[i].e);
        end
        $display("table done");
        // Host writes pile up while the local side stalls; ninth is dropped
        for (int i = 0; i < 9; i++) xfer(1'b1, hup_pkg::REG_DATA, 8'h80 + i[7:0]);
        xfer(1'b0, hup_pkg::REG_STATUS, 8'h00);
        chk8(q, 8'h00);
        rx_from_host_ready_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            n = 0;
            while (rx_from_host_valid_o !== 1'b1 && n < 20) begin
                @(negedge clk_i);
                n++;
            end
            chk8(rx_from_host_data_o, 8'h80 + i[7:0]);
            @(negedge clk_i);
        end
        chk1(rx_from_host_valid_o, 1'b0);
        $display("host write fifo done");
        for (int i = 0; i < 8; i++) begin
            tx_to_host_valid_i = 1'b1;
            tx_to_host_data_i = 8'h40 + i[7:0];
            @(negedge clk_i);
        end
        tx_to_host_valid_i = 1'b0;
        chk1(tx_to_host_ready_o, 1'b0);
        xfer(1'b1, hup_pkg::REG_IRQ_EN, 8'h09);
        // Commit at strobe release, then two sync flops on the host side
        wait_n(12);
        chk1(irq_o, 1'b1);
        chk1(hup_if_inst.rx_byte_ready_n, 1'b0);
        chk1(hup_if_inst.tx_slot_free_n, 1'b0);
        chk1(rx_byte_ready_o, 1'b1);
        chk1(tx_slot_free_o, 1'b1);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, hup_pkg::REG_DATA, 8'h00);
            chk8(q, 8'h40 + i[7:0]);
        end
        wait_n(6);
        chk1(irq_o, 1'b0);
        chk1(rx_byte_ready_o, 1'b0);
        chk1(tx_to_host_ready_o, 1'b1);
        $display("host read fifo done");
        xfer(1'b1, hup_pkg::REG_IRQ_EN, 8'h02);
        wait_n(12);
        chk1(irq_o, 1'b1);
        chk1(tx_slot_free_o, 1'b0);
        reset_i = 1'b1;
        wait_n(2);
        reset_i = 1'b0;
        chk1(hup_if_inst.irq, 1'b0);
        xfer(1'b0, hup_pkg::REG_IRQ_EN, 8'h00);
        chk8(q, hup_pkg::IEN_RESET);
        $display("irq and reset done");
        hup_if_inst.mode_i = 1'b0;
        general_port_a_out_i = 8'h5a;
        general_port_a_oe_i = 8'hff;
        {serial_b_terminal_ready_request_i, clocked_serial_transmit_i} = 2'b11;
        {serial_b_wait_request_i, clocked_serial_clock_i} = 2'b00;
        {serial_b_request_to_send_i, dma1_transfer_end_n_i} = 2'b00;
        wait_n(3);
        chk8(hup_if_inst.host_data_bus, 8'h5a);
        chk8(general_port_a_in_o, 8'h5a);
        chk1(hup_if_inst.buffer_off_n, 1'b0);
        chk1(serial_b_sync_o, hup_if_inst.select_n);
        chk1(serial_b_clear_to_send_o, hup_if_inst.write_n);
        chk1(serial_b_carrier_detect_o, hup_if_inst.read_n);
        chk1(serial_b_trx_clock_o, hup_if_inst.reg_sel[0]);
        chk1(serial_b_receive_data_o, hup_if_inst.reg_sel[1]);
        chk1(serial_b_rtx_clock_o, hup_if_inst.reg_sel[2]);
        chk1(hup_if_inst.irq, 1'b1);
        chk1(hup_if_inst.tx_slot_free_n, 1'b0);
        chk1(hup_if_inst.rx_byte_ready_n, 1'b0);
        serial_b_transmit_data_i = 1'b1;
        {csio_transmit_select_i, csio_clock_select_i, dma1_end_select_i} = 3'b111;
        {clocked_serial_transmit_i, clocked_serial_clock_i} = 2'b01;
        dma1_transfer_end_n_i = 1'b1;
        wait_n(3);
        chk1(hup_if_inst.buffer_off_n, 1'b1);
        chk1(hup_if_inst.irq, 1'b0);
        chk1(hup_if_inst.tx_slot_free_n, 1'b1);
        chk1(hup_if_inst.rx_byte_ready_n, 1'b1);
        $display("mode 0 done");
        summarize();
    end
endmodule // tb_top
